// ### core/scd_dispatch.sv
// service and adjustment command dispatcher
//
// Function
// - code 1 enters service; only with no weighing cycle running
// - unadjusted scale refuses to leave service
// - code 2 leaves service; only while in service
// - weighing commands allowed only once service is off after adjustment
// - code 3 in service captures dead-load as zero point
// - codes 4..7 in service capture weight as adjustment weights 1..4
// - code 8 in service restores factory parameters
// - code 9 always acknowledges errors; error state left only if none remain
// - code 10, with no cycle running or in service, checks load-cell impedance against reference
// - code 11, with no cycle running or in service, stores impedance reference
// - code 12 in service off host bus enables stand-alone, kept non-volatile
// - stand-alone cleared as soon as operated on the host bus
// - code 13 in service disables stand-alone
// - code 14 resets slave pointer to 0
// - in fault/error state only 8,1,2,9,108 accepted; others error 21
`timescale 1ns/100ps
`include "scd_params.svh"
module scd_dispatch
  import scd_pkg::*;
#(
  parameter int WW = 24
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic cycle_active,
  input wire logic on_host_bus,
  input wire logic hw_fault,
  input wire logic other_errors,
  input wire logic [WW-1:0] weight_in,
  input wire logic [WW-1:0] imp_meas,
  input wire logic sa_nv_in,
  output scd_mode_s mode,
  output scd_result_s result,
  output logic weigh_enable,
  output logic [WW-1:0] zero_pt,
  output logic [WW-1:0] adj_wt [4],
  output logic [WW-1:0] imp_ref,
  output logic imp_ok,
  output logic factory_pulse,
  output logic sa_nv_write,
  output logic [15:0] slave_ptr
);
  if (WW < 1) begin : g_ww_check
    $error("width too small");
  end

  // ==========================================================
  // command legality
  function automatic logic legal_in_fault(input logic [7:0] c);
    return c == `SCD_CMD_FACTORY || c == `SCD_CMD_SRV_ON || c == `SCD_CMD_SRV_OFF
      || c == `SCD_CMD_ACK || c == `SCD_CMD_ABORT;
  endfunction : legal_in_fault

  scd_mode_s mode_ff, nxt_mode;
  scd_result_s res_ff, nxt_res;
  logic [WW-1:0] zero_ff, nxt_zero;
  logic [WW-1:0] adj_ff [4];
  logic [WW-1:0] nxt_adj [4];
  logic [WW-1:0] ref_ff, nxt_ref;
  logic imp_ok_ff, nxt_imp_ok;
  logic fac_ff, nxt_fac;
  logic nvw_ff, nxt_nvw;
  logic [15:0] ptr_ff, nxt_ptr;
  logic nv_loaded_ff, nxt_nv_loaded;
  logic [2:0] bus_sync_ff, nxt_bus_sync;
  logic bus_q_ff, nxt_bus_q;
  logic faulted;

  assign faulted = mode_ff.err_state || hw_fault;

  // ==========================================================
  // next-state logic
  always_comb begin
    logic ok;
    logic [7:0] ec;
    ok = 1'b0;
    ec = `SCD_ERR_NONE;
    nxt_mode = mode_ff;
    nxt_zero = zero_ff;
    nxt_adj = adj_ff;
    nxt_ref = ref_ff;
    nxt_imp_ok = imp_ok_ff;
    nxt_fac = 1'b0;
    nxt_nvw = 1'b0;
    nxt_ptr = ptr_ff;
    nxt_res = '{done: 1'b0, err: 1'b0, err_code: `SCD_ERR_NONE};
    nxt_nv_loaded = 1'b1;
    nxt_bus_sync = {bus_sync_ff[1:0], on_host_bus};
    nxt_bus_q = (bus_sync_ff[2] == bus_sync_ff[1]) ? bus_sync_ff[2] : bus_q_ff;
    if (!nv_loaded_ff) begin
      nxt_mode.standalone = sa_nv_in;
    end
    if (hw_fault) begin
      nxt_mode.err_state = 1'b1;
    end
    if (cmd_valid) begin
      if (faulted && !legal_in_fault(cmd_code)) begin
        ec = `SCD_ERR_FAULT;
      end else begin
        unique case (cmd_code)
          `SCD_CMD_SRV_ON: ok = !cycle_active;
          `SCD_CMD_SRV_OFF: ok = mode_ff.srv && mode_ff.adjusted;
          `SCD_CMD_ZERO, `SCD_CMD_FACTORY, `SCD_CMD_SA_OFF: ok = mode_ff.srv;
          8'h04, 8'h05, 8'h06, `SCD_CMD_ADJ4: ok = mode_ff.srv;
          `SCD_CMD_ACK: ok = 1'b1;
          `SCD_CMD_IMP_CHK, `SCD_CMD_IMP_REF: ok = !cycle_active || mode_ff.srv;
          `SCD_CMD_SA_ON: ok = mode_ff.srv && !bus_q_ff;
          `SCD_CMD_PTR_CLR: ok = 1'b1;
          `SCD_CMD_ABORT: ok = 1'b1;
          default: ok = 1'b0;
        endcase
        if (!ok) begin
          ec = (cmd_code > `SCD_CMD_PTR_CLR && cmd_code != `SCD_CMD_ABORT)
            ? `SCD_ERR_UNKNOWN : `SCD_ERR_STATE;
        end
      end
      nxt_res = '{done: 1'b1, err: !ok, err_code: ec};
      if (ok) begin
        unique case (cmd_code)
          `SCD_CMD_SRV_ON: nxt_mode.srv = 1'b1;
          `SCD_CMD_SRV_OFF: nxt_mode.srv = 1'b0;
          `SCD_CMD_ZERO: nxt_zero = weight_in;
          8'h04, 8'h05, 8'h06, `SCD_CMD_ADJ4: begin
            nxt_adj[2'(cmd_code - `SCD_CMD_ADJ1)] = weight_in;
            nxt_mode.adjusted = 1'b1;
          end
          `SCD_CMD_FACTORY: begin
            nxt_fac = 1'b1;
            nxt_mode.adjusted = 1'b0;
            nxt_zero = '0;
            nxt_ref = '0;
            for (int i = 0; i < 4; i++) begin
              nxt_adj[i] = '0;
            end
          end
          `SCD_CMD_ACK: nxt_mode.err_state = hw_fault || other_errors;
          `SCD_CMD_IMP_CHK: nxt_imp_ok = imp_meas == ref_ff;
          `SCD_CMD_IMP_REF: nxt_ref = imp_meas;
          `SCD_CMD_SA_ON: begin
            nxt_mode.standalone = 1'b1;
            nxt_nvw = 1'b1;
          end
          `SCD_CMD_SA_OFF: begin
            nxt_mode.standalone = 1'b0;
            nxt_nvw = mode_ff.standalone;
          end
          `SCD_CMD_PTR_CLR: nxt_ptr = `SCD_PTR_RESET;
          default: nxt_ptr = ptr_ff;
        endcase
      end
    end
    if (bus_q_ff && nxt_mode.standalone) begin
      nxt_mode.standalone = 1'b0;
      nxt_nvw = 1'b1;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      mode_ff <= '0;
      res_ff <= '0;
      zero_ff <= '0;
      for (int i = 0; i < 4; i++) begin
        adj_ff[i] <= '0;
      end
      ref_ff <= '0;
      imp_ok_ff <= 1'b0;
      fac_ff <= 1'b0;
      nvw_ff <= 1'b0;
      ptr_ff <= `SCD_PTR_RESET;
      nv_loaded_ff <= 1'b0;
      bus_sync_ff <= 3'h0;
      bus_q_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      res_ff <= nxt_res;
      zero_ff <= nxt_zero;
      adj_ff <= nxt_adj;
      ref_ff <= nxt_ref;
      imp_ok_ff <= nxt_imp_ok;
      fac_ff <= nxt_fac;
      nvw_ff <= nxt_nvw;
      ptr_ff <= nxt_ptr;
      nv_loaded_ff <= nxt_nv_loaded;
      bus_sync_ff <= nxt_bus_sync;
      bus_q_ff <= nxt_bus_q;
    end
  end

  assign mode = mode_ff;
  assign result = res_ff;
  assign weigh_enable = mode_ff.adjusted && !mode_ff.srv && !mode_ff.err_state;
  assign zero_pt = zero_ff;
  assign adj_wt = adj_ff;
  assign imp_ref = ref_ff;
  assign imp_ok = imp_ok_ff;
  assign factory_pulse = fac_ff;
  assign sa_nv_write = nvw_ff;
  assign slave_ptr = ptr_ff;

  // ==========================================================
  // assertions
  a_srv_on_blocked: assert property (@(posedge mclk) disable iff (rst)
    cmd_valid && cmd_code == `SCD_CMD_SRV_ON && cycle_active && !mode_ff.srv
    |=> !mode_ff.srv && res_ff.err) else $error("service entered during cycle");
  a_unadj_stays: assert property (@(posedge mclk) disable iff (rst)
    mode_ff.srv && !mode_ff.adjusted |=> mode_ff.srv) else $error("left service unadjusted");
  a_srv_off_ok: assert property (@(posedge mclk) disable iff (rst)
    $fell(mode_ff.srv) |-> $past(cmd_valid) && $past(cmd_code) == `SCD_CMD_SRV_OFF)
    else $error("service left without code 2");
  a_weigh_gate: assert property (@(posedge mclk) disable iff (rst)
    $rose(weigh_enable) |-> $past(cmd_valid)
      && ($past(cmd_code) == `SCD_CMD_SRV_OFF || $past(cmd_code) == `SCD_CMD_ACK))
    else $error("weighing enabled without leaving service");
  a_zero_cap: assert property (@(posedge mclk) disable iff (rst)
    cmd_valid && cmd_code == `SCD_CMD_ZERO && mode_ff.srv && !faulted
    |=> zero_ff == $past(weight_in)) else $error("zero not captured");
  a_fault_reject: assert property (@(posedge mclk) disable iff (rst)
    cmd_valid && faulted && !legal_in_fault(cmd_code)
    |=> res_ff.err && res_ff.err_code == `SCD_ERR_FAULT) else $error("fault reject missing");
  a_refuse_hold: assert property (@(posedge mclk) disable iff (rst)
    cmd_valid && !mode_ff.srv && cmd_code == `SCD_CMD_ZERO
    |=> res_ff.err && $stable(zero_ff)) else $error("refused command changed state");
  a_bus_clears_sa: assert property (@(posedge mclk) disable iff (rst)
    bus_q_ff |=> !mode_ff.standalone) else $error("stand-alone kept on bus");
  a_ptr_clear: assert property (@(posedge mclk) disable iff (rst)
    cmd_valid && cmd_code == `SCD_CMD_PTR_CLR && !faulted |=> ptr_ff == `SCD_PTR_RESET)
    else $error("pointer not cleared");
endmodule : scd_dispatch

// ### core/scd_params.svh
// constants of the service command dispatcher
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH
`define SCD_CMD_SRV_ON 8'h01
`define SCD_CMD_SRV_OFF 8'h02
`define SCD_CMD_ZERO 8'h03
`define SCD_CMD_ADJ1 8'h04
`define SCD_CMD_ADJ4 8'h07
`define SCD_CMD_FACTORY 8'h08
`define SCD_CMD_ACK 8'h09
`define SCD_CMD_IMP_CHK 8'h0A
`define SCD_CMD_IMP_REF 8'h0B
`define SCD_CMD_SA_ON 8'h0C
`define SCD_CMD_SA_OFF 8'h0D
`define SCD_CMD_PTR_CLR 8'h0E
`define SCD_CMD_ABORT 8'h6C
`define SCD_ERR_NONE 8'h00
`define SCD_ERR_FAULT 8'h15
`define SCD_ERR_STATE 8'h01
`define SCD_ERR_UNKNOWN 8'h02
`define SCD_PTR_RESET 16'h0000
`endif

// ### core/scd_pkg.sv
// types of the service command dispatcher
package scd_pkg;
  typedef struct packed {
    logic srv;
    logic standalone;
    logic err_state;
    logic adjusted;
  } scd_mode_s;
  typedef struct packed {
    logic done;
    logic err;
    logic [7:0] err_code;
  } scd_result_s;
endpackage : scd_pkg

// ### verif/scd_host.sv
// host model that issues numbered commands to the dispatcher
`timescale 1ns/100ps
module scd_host (
  input wire logic mclk,
  output logic cmd_valid,
  output logic [7:0] cmd_code
);
  // ====
  // command issue
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'hFF;
  end
  task automatic send(input logic [7:0] c);
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code <= c;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_code <= ~c; // idle code moves away from the last one
  endtask : send
endmodule : scd_host

// ### verif/scd_dispatch_tb_top.sv
// self-checking bench of the service command dispatcher
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_fail++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module scd_dispatch_tb_top
  import scd_pkg::*;
;
  // ====
  // design and host
  logic mclk = 1'b0, rst = 1'b1, cycle_active = 1'b0, on_host_bus = 1'b0, hw_fault = 1'b0;
  logic other_errors = 1'b0, sa_nv_in = 1'b1, cmd_valid, weigh_enable, imp_ok;
  logic factory_pulse, sa_nv_write;
  logic [7:0] cmd_code;
  logic [23:0] weight_in = 24'h000000, imp_meas = 24'h000000, w, zero_pt, imp_ref;
  logic [23:0] adj_wt [4];
  logic [15:0] slave_ptr;
  logic [8:0] ex;
  logic [8:0] exp_q[$];
  scd_mode_s mode;
  scd_result_s result;
  int n_fail = 0, comparisons = 0;
  always #50 mclk = ~mclk;
  scd_host i_host (.mclk(mclk), .cmd_valid(cmd_valid), .cmd_code(cmd_code));
  scd_dispatch #(.WW(24)) i_scd_dispatch (.mclk(mclk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cycle_active(cycle_active), .on_host_bus(on_host_bus),
    .hw_fault(hw_fault), .other_errors(other_errors), .weight_in(weight_in),
    .imp_meas(imp_meas), .sa_nv_in(sa_nv_in), .mode(mode), .result(result),
    .weigh_enable(weigh_enable), .zero_pt(zero_pt), .adj_wt(adj_wt), .imp_ref(imp_ref),
    .imp_ok(imp_ok), .factory_pulse(factory_pulse), .sa_nv_write(sa_nv_write),
    .slave_ptr(slave_ptr));
  // ====
  // checking and sequence
  always @(negedge mclk) begin
    if (!rst && result.done === 1'b1) begin
      ex = (exp_q.size() > 0) ? exp_q.pop_front() : 9'h1FF;
      `CHK({result.err, result.err_code}, ex)
    end
  end
  task automatic cmd(input logic [7:0] c, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.send(c);
    @(negedge mclk);
  endtask : cmd
  task automatic print_verdict;
    $display("counts comparisons=%0d n_fail=%0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
  initial begin
    w = 24'($urandom(17));
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(negedge mclk);
    `CHK(mode.standalone, 1'b1)
    cmd(8'h02, 9'h101);
    @(posedge mclk) cycle_active <= 1'b1;
    cmd(8'h01, 9'h101);
    @(posedge mclk) cycle_active <= 1'b0;
    cmd(8'h01, 9'h000);
    `CHK(mode.srv, 1'b1)
    cmd(8'h02, 9'h101);
    `CHK(mode.srv, 1'b1)
    cmd(8'h0D, 9'h000);
    `CHK(mode.standalone, 1'b0)
    `CHK(sa_nv_write, 1'b1)
    for (int k = 0; k < 5; k++) begin
      w = 24'($urandom);
      @(posedge mclk) weight_in <= w;
      cmd(8'(3 + k), 9'h000);
      if (k == 0) `CHK(zero_pt, w)
      else `CHK(adj_wt[k-1], w)
    end
    $display("adjustment test done");
    cmd(8'h0C, 9'h000);
    `CHK(mode.standalone, 1'b1)
    `CHK(sa_nv_write, 1'b1)
    @(posedge mclk) on_host_bus <= 1'b1;
    repeat (6) @(negedge mclk);
    `CHK(mode.standalone, 1'b0)
    `CHK(sa_nv_write, 1'b1)
    cmd(8'h0C, 9'h101);
    @(posedge mclk) on_host_bus <= 1'b0;
    cmd(8'h02, 9'h000);
    `CHK({mode.srv, weigh_enable}, 2'b01)
    @(posedge mclk) imp_meas <= w;
    cmd(8'h0B, 9'h000);
    `CHK(imp_ref, w)
    cmd(8'h0A, 9'h000);
    `CHK(imp_ok, 1'b1)
    @(posedge mclk) imp_meas <= w + 24'h000001;
    cmd(8'h0A, 9'h000);
    `CHK(imp_ok, 1'b0)
    cmd(8'h0E, 9'h000);
    `CHK(slave_ptr, 16'h0000)
    cmd(8'h20, 9'h102);
    $display("mode test done");
    @(posedge mclk) {hw_fault, other_errors} <= 2'b11;
    repeat (3) @(negedge mclk);
    cmd(8'h03, 9'h115);
    cmd(8'h6C, 9'h000);
    cmd(8'h09, 9'h000);
    @(posedge mclk) hw_fault <= 1'b0;
    cmd(8'h09, 9'h000);
    `CHK(mode.err_state, 1'b1)
    @(posedge mclk) other_errors <= 1'b0;
    cmd(8'h09, 9'h000);
    `CHK(mode.err_state, 1'b0)
    cmd(8'h01, 9'h000);
    cmd(8'h08, 9'h000);
    `CHK({mode.adjusted, zero_pt}, 25'h0000000)
    `CHK(factory_pulse, 1'b1)
    repeat (2) @(negedge mclk);
    `CHK(exp_q.size() == 0, 1'b1)
    $display("error test done");
    print_verdict();
  end
endmodule : scd_dispatch_tb_top
